//--- hw/dacsp_cfg.svh
// Constants of the converter serial port: frame layout, command codes and reset values.
`ifndef DACSP_CFG_SVH
`define DACSP_CFG_SVH
`define DACSP_FRAME_BITS   24
`define DACSP_CNT_W        6
`define DACSP_ZERO_BIT     20
`define DACSP_CMD_HI       19
`define DACSP_CMD_LO       16
`define DACSP_DATA_HI      15
`define DACSP_REFDIS_BIT   5
`define DACSP_CMD_NOP      4'h0
`define DACSP_CMD_WR_IN    4'h1
`define DACSP_CMD_UPD      4'h2
`define DACSP_CMD_WR_UPD   4'h3
`define DACSP_CMD_WR_CTRL  4'h4
`define DACSP_CMD_DRST     4'h7
`define DACSP_CMD_NO_DAISY 4'h9
`define DACSP_CMD_RB_IN    4'hA
`define DACSP_CMD_RB_DAC   4'hB
`define DACSP_CMD_RB_CTRL  4'hC
`define DACSP_CMD_FRST     4'hF
`define DACSP_DATA_RST     16'h0000
`define DACSP_CTRL_RST     16'h0000
`define DACSP_PIN_IDLE     4'h9
`endif

//--- hw/dacsp_pkg.sv
// Types shared by the converter serial port design.
package dacsp_pkg;
  typedef struct packed {
    logic frame_n;
    logic sclk;
    logic sdi;
    logic load_n;
  } dacsp_pins_t;

  typedef struct packed {
    logic [15:0] input_reg;
    logic [15:0] dac_reg;
    logic [15:0] ctrl_reg;
  } dacsp_regs_t;
endpackage

//--- hw/dacsp_port.sv
// Serial slave port of a single-channel converter with readback and daisy chaining.
`timescale 1ns/1ns
`include "dacsp_cfg.svh"
// Overview of operation
// R1 - One 24-bit word per device per frame.
// R2 - Host holds frame low for whole word.
// R3 - Input sampled on falling serial clock edges.
// R4 - Frame rise captures word and decodes command.
// R5 - Continuous clock needs exact frame length.
// R6 - Gated burst exact, then frame rises.
// R7 - Host gives exactly 24 falling edges.
// R8 - Fewer than 24 edges: word ignored.
// R9 - Standalone, more than 24 edges: ignored.
// R10 - Host lowers frame again per transfer.
// R11 - Valid frame loads addressed register.
// R12 - Load strobe low while idle updates output.
// R13 - Read command, next frame shifts register out.
// R14 - Frame high makes serial output high-Z.
// R15 - Host reads single register with no-op.
// R16 - Readback pipelined with next read command.
// R17 - Serial output enabled by default.
// R18 - Extra bits ripple out in daisy chain.
// R19 - Output changes on rising clock edge.
// R20 - Host gives 24 times N clocks.
// R21 - Frame rise latches, no more input.
// R22 - Reference on at reset, bit disables.
// R23 - MSB first; bit 20 zero; command 19:16.
// R24 - Command codes decoded as listed.
// R25 - Load low during frame updates at rise.
// R26 - Bit counter cleared at frame start.
module dacsp_port
  import dacsp_pkg::*;
(
  input  wire logic                 clk_sys_i,
  input  wire logic                 sys_rst_i,
  input  wire dacsp_pkg::dacsp_pins_t pins_i,
  output logic                      sdo_o,
  output logic                      sdo_oe_o,
  output dacsp_pkg::dacsp_regs_t    regs_o,
  output logic                      ref_enable_o,
  output logic                      reset_pulse_o
);
  import dacsp_pkg::*;

  localparam int NB = `DACSP_FRAME_BITS;

  dacsp_pins_t s;
  dacsp_pins_t p_r;
  logic [NB-1:0]              shift_r;
  logic [`DACSP_CNT_W-1:0]    cnt_r;
  logic                       over_r;
  logic                       load_seen_r;
  logic                       daisy_en_r;
  logic [NB-1:0]              rb_r;
  logic                       rb_pend_r;
  logic [15:0]                rb_nxt;
  logic                       sdo_src_r;
  logic [3:0]                 cmd;
  logic [15:0]                dat;
  logic [15:0]                in_r;
  logic [15:0]                dac_r;
  logic [15:0]                ctrl_r;
  logic                       frame_fall;
  logic                       frame_rise;
  logic                       sclk_fall;
  logic                       sclk_rise;
  logic                       valid;
  logic                       accept;
  logic                       rd_cmd;
  logic                       wr_in;
  logic                       upd;
  logic                       wr_upd;
  logic                       wr_ctrl;
  logic                       data_rst;
  logic                       no_daisy;
  logic                       full_rst;

  dacsp_sync #(.W(4)) u_sync (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (pins_i),
    .rst_val_i (`DACSP_PIN_IDLE),
    .sync_o    (s)
  );

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) p_r <= `DACSP_PIN_IDLE;
    else           p_r <= s;
  end

  assign frame_fall = p_r.frame_n & ~s.frame_n;
  assign frame_rise = ~p_r.frame_n & s.frame_n;
  assign sclk_fall  = ~s.frame_n & p_r.sclk & ~s.sclk;
  assign sclk_rise  = ~s.frame_n & ~p_r.sclk & s.sclk;
  assign cmd        = shift_r[`DACSP_CMD_HI:`DACSP_CMD_LO];
  assign dat        = shift_r[`DACSP_DATA_HI:0];
  // Daisy mode accepts longer frames; the last 24 bits are ours. [R9] [R20]
  assign valid      = (cnt_r == `DACSP_CNT_W'(NB) && !over_r) ||
                      (daisy_en_r && (cnt_r >= `DACSP_CNT_W'(NB) || over_r)); // [R8] [R1]

  // Shift register and bit count. [R3] [R23] [R26] [R21]
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      shift_r <= '0;
      cnt_r   <= '0;
      over_r  <= 1'b0;
    end else if (frame_fall) begin
      cnt_r  <= '0; // [R26]
      over_r <= 1'b0;
    end else if (sclk_fall) begin
      shift_r <= {shift_r[NB-2:0], s.sdi}; // [R3]
      if (cnt_r == `DACSP_CNT_W'(NB)) over_r <= 1'b1; // [R9]
      else cnt_r <= cnt_r + `DACSP_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i)       load_seen_r <= 1'b0;
    else if (frame_fall) load_seen_r <= ~s.load_n;
    else if (!s.frame_n && !s.load_n) load_seen_r <= 1'b1; // [R25]
  end

  // A frame is accepted at its end; each write, update, reset and daisy-disable command becomes a one-cycle strobe. [R4] [R24]
  assign accept   = frame_rise && valid && !shift_r[`DACSP_ZERO_BIT]; // [R23]
  assign rd_cmd   = cmd == `DACSP_CMD_RB_IN || cmd == `DACSP_CMD_RB_DAC ||
                    cmd == `DACSP_CMD_RB_CTRL;
  assign wr_in    = accept && cmd == `DACSP_CMD_WR_IN;
  assign upd      = accept && cmd == `DACSP_CMD_UPD;
  assign wr_upd   = accept && cmd == `DACSP_CMD_WR_UPD;
  assign wr_ctrl  = accept && cmd == `DACSP_CMD_WR_CTRL;
  assign data_rst = accept && cmd == `DACSP_CMD_DRST;
  assign no_daisy = accept && cmd == `DACSP_CMD_NO_DAISY;
  assign full_rst = accept && cmd == `DACSP_CMD_FRST;
  assign regs_o   = {in_r, dac_r, ctrl_r};

  // Input register takes the data field of a write-input or write-and-update command. [R11]
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || data_rst || full_rst) begin
      in_r <= `DACSP_DATA_RST;
    end else if (wr_in || wr_upd) begin
      in_r <= dat; // [R11]
    end
  end

  // Output register follows the input register on update, strobe or frame load. [R12] [R25]
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || data_rst || full_rst) begin
      dac_r <= `DACSP_DATA_RST;
    end else if (wr_upd || (wr_in && load_seen_r)) begin
      dac_r <= dat; // [R25]
    end else if (upd) begin
      dac_r <= in_r; // [R24]
    end else if (s.frame_n && !s.load_n) begin
      dac_r <= in_r; // [R12]
    end
  end

  // Control register and the reference switch it carries. [R22]
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || full_rst) begin
      ctrl_r       <= `DACSP_CTRL_RST;
      ref_enable_o <= 1'b1; // [R22]
    end else if (wr_ctrl) begin
      ctrl_r       <= dat;
      ref_enable_o <= ~dat[`DACSP_REFDIS_BIT]; // [R22]
    end
  end

  // Daisy chaining stays on until the disable command. [R9] [R18]
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || full_rst) begin
      daisy_en_r <= 1'b1;
    end else if (no_daisy) begin
      daisy_en_r <= 1'b0;
    end
  end

  // One-cycle pulse on a full reset command. [R24]
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      reset_pulse_o <= 1'b0;
    end else begin
      reset_pulse_o <= full_rst;
    end
  end

  // Readback source chosen at frame end, shifted out in the next frame. [R13] [R16]
  always_comb begin
    unique case (cmd)
      `DACSP_CMD_RB_IN:  rb_nxt = regs_o.input_reg;
      `DACSP_CMD_RB_DAC: rb_nxt = regs_o.dac_reg;
      default:           rb_nxt = regs_o.ctrl_reg;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rb_r      <= '0;
      rb_pend_r <= 1'b0;
    end else if (frame_rise) begin
      rb_pend_r <= accept && rd_cmd; // [R13]
      rb_r      <= {shift_r[NB-1:16], rb_nxt}; // [R16]
    end else if (sclk_fall && rb_pend_r) begin
      rb_r <= {rb_r[NB-2:0], 1'b0};
    end
  end

  // Output bit changes on rising clock; ripples shift MSB in daisy mode. [R18] [R19]
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i)        sdo_src_r <= 1'b0;
    else if (frame_fall)  sdo_src_r <= rb_pend_r ? rb_r[NB-1] : shift_r[NB-1];
    else if (sclk_rise)   sdo_src_r <= rb_pend_r ? rb_r[NB-1] : shift_r[NB-1]; // [R19]
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sdo_o    <= 1'b0;
      sdo_oe_o <= 1'b0;
    end else begin
      sdo_o    <= sdo_src_r;
      sdo_oe_o <= ~s.frame_n & (rb_pend_r | daisy_en_r); // [R14] [R17]
    end
  end
endmodule

//--- hw/dacsp_sync.sv
// Two-flop synchroniser for the four serial port input pins.
`timescale 1ns/1ns
module dacsp_sync #(
  parameter int W = 4
) (
  input  wire logic         clk_sys_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] async_i,
  input  wire logic [W-1:0] rst_val_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_r;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
          meta_r[g] <= rst_val_i[g];
          sync_o[g] <= rst_val_i[g];
        end else begin
          meta_r[g] <= async_i[g];
          sync_o[g] <= meta_r[g];
        end
      end
    end
  endgenerate
endmodule

//--- verification/dac_serial_port_daisy_chain_test.sv
// Self-checking bench for the converter serial port.
`timescale 1ns/1ns
`include "dacsp_cfg.svh"
module dac_serial_port_daisy_chain_test;
  import dacsp_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  dacsp_pins_t pins;
  dacsp_regs_t regs;
  logic        sdo, oe, ref_en, rst_p;
  logic [47:0] rx;
  int          failures = 0;
  int          cmp_count = 0;
  int          pulses = 0;
  always #20 clk_sys_i = ~clk_sys_i;
  always @(negedge clk_sys_i) begin
    if (rst_p) pulses++;
  end
  dacsp_host u_host (.clk_sys_i(clk_sys_i), .sdo_i(sdo), .pins_o(pins));
  dacsp_port u_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .pins_i(pins), .sdo_o(sdo),
    .sdo_oe_o(oe), .regs_o(regs), .ref_enable_o(ref_en), .reset_pulse_o(rst_p));
  function automatic logic [47:0] wd(input logic [3:0] c, input logic [15:0] d);
    return {24'h0, 4'hA, c, d};
  endfunction
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic sf(input logic [47:0] w, input int n, input logic ld);
    u_host.xfer(w, n, ld, rx);
  endtask
  task automatic t_write();
    sf(wd(`DACSP_CMD_WR_IN, 16'hA5C3), 24, 1'b1);
    chk("wr", {16'hA5C3, 32'h0}, regs);
    chk("oe", 48'h0, {47'h0, oe});
    sf(wd(`DACSP_CMD_WR_IN, 16'h1234), 23, 1'b1);
    chk("short", {16'hA5C3, 32'h0}, regs);
    sf(wd(`DACSP_CMD_WR_IN, 16'h1234) | 48'h100000, 24, 1'b1);
    chk("bit20", {16'hA5C3, 32'h0}, regs);
    u_host.strobe();
    chk("strobe", {16'hA5C3, 16'hA5C3, 16'h0}, regs);
  endtask
  task automatic t_read();
    sf(wd(`DACSP_CMD_WR_CTRL, 16'h0020), 24, 1'b1);
    chk("ref", {16'h0020, 1'b0}, {regs.ctrl_reg, ref_en});
    sf(wd(`DACSP_CMD_RB_IN, 16'h0), 24, 1'b1);
    sf(wd(`DACSP_CMD_RB_CTRL, 16'h0), 24, 1'b1);
    chk("rb_pipe", 48'hA5C3, {32'h0, rx[15:0]});
    sf(wd(`DACSP_CMD_NOP, 16'h0), 24, 1'b1);
    chk("rb_nop", 48'h0020, {32'h0, rx[15:0]});
  endtask
  task automatic t_daisy();
    sf(48'h5A0F3C000000 | wd(`DACSP_CMD_WR_UPD, 16'h7777), 48, 1'b1);
    chk("ripple", 64'hA000005A0F3C, rx);
    chk("chain", {16'h7777, 16'h7777, 16'h0020}, regs);
  endtask
  task automatic t_alone();
    sf(wd(`DACSP_CMD_NO_DAISY, 16'h0), 24, 1'b1);
    sf(wd(`DACSP_CMD_WR_IN, 16'h3333), 25, 1'b1);
    chk("long", {16'h7777, 16'h7777, 16'h0020}, regs);
    sf(wd(`DACSP_CMD_WR_IN, 16'h4242), 24, 1'b0);
    chk("sync_ld", {16'h4242, 16'h4242, 16'h0020}, regs);
    sf(wd(`DACSP_CMD_FRST, 16'h0), 24, 1'b1);
    chk("frst", 48'h1, {regs, ref_en});
    chk("pulse", 64'h1, pulses);
  endtask
  task automatic t_cmds();
    sf(wd(`DACSP_CMD_WR_IN, 16'h1357), 24, 1'b1);
    sf(wd(`DACSP_CMD_UPD, 16'h0), 24, 1'b1);
    chk("upd", {16'h1357, 16'h1357, 16'h0}, regs);
    sf(wd(`DACSP_CMD_RB_DAC, 16'h0), 24, 1'b1);
    sf(wd(`DACSP_CMD_NOP, 16'h0), 24, 1'b1);
    chk("rb_dac", 64'hAB1357, rx[23:0]);
    sf(wd(`DACSP_CMD_DRST, 16'h0), 24, 1'b1);
    chk("drst", 64'h0, regs);
  endtask
  task automatic print_verdict();
    $display("failures %0d compares %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    repeat (6) @(negedge clk_sys_i);
    chk("reset", 48'h1, {regs, ref_en});
    t_write();
    t_read();
    t_daisy();
    t_alone();
    t_cmds();
    print_verdict();
  end
  initial begin
    #(40 * 20000);
    failures++;
    print_verdict();
  end
endmodule

//--- verification/dacsp_host.sv
// Host controller model that drives the serial port pins.
`timescale 1ns/1ns
module dacsp_host (
  input  wire logic            clk_sys_i,
  input  wire logic            sdo_i,
  output dacsp_pkg::dacsp_pins_t pins_o
);
  import dacsp_pkg::*;
  initial pins_o = 4'h9;
  task automatic hold(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic xfer(input logic [47:0] w, input int n, input logic ld_n,
                      output logic [47:0] rx);
    rx = 48'h0;
    pins_o.frame_n = 1'b0;
    pins_o.load_n = ld_n;
    hold(3);
    for (int i = n - 1; i >= 0; i--) begin
      pins_o.sclk = 1'b1;
      pins_o.sdi = w[i];
      hold(5);
      rx = {rx[46:0], sdo_i};
      pins_o.sclk = 1'b0;
      hold(3);
    end
    pins_o.frame_n = 1'b1;
    pins_o.load_n = 1'b1;
    pins_o.sdi = ~pins_o.sdi;
    hold(8);
  endtask
  task automatic strobe();
    pins_o.load_n = 1'b0;
    hold(4);
    pins_o.load_n = 1'b1;
    hold(6);
  endtask
endmodule

//--- verification/dacsp_port_assertions.sv
// Property checker of the converter serial port.
`timescale 1ns/1ns
`include "dacsp_cfg.svh"
module dacsp_port_assertions
  import dacsp_pkg::*;
(
  input wire logic                   clk_sys_i,
  input wire logic                   sys_rst_i,
  input wire dacsp_pkg::dacsp_pins_t pins_i,
  input wire logic                   sdo_o,
  input wire logic                   sdo_oe_o,
  input wire dacsp_pkg::dacsp_regs_t regs_o,
  input wire logic                   ref_enable_o,
  input wire logic                   reset_pulse_o
);
  logic [3:0] hi_r;
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || !pins_i.frame_n) hi_r <= 4'h0;
    else if (hi_r != 4'hF) hi_r <= hi_r + 4'h1;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  chk_oe_idle: assert property (pins_i.frame_n [*5] |-> !sdo_oe_o) else $error("oe idle");
  chk_word_time: assert property ($changed({regs_o.input_reg, regs_o.ctrl_reg}) |->
    hi_r inside {[2:8]}) else $error("word update timing");
  chk_dac_time: assert property ($changed(regs_o.dac_reg) |-> hi_r >= 4'h2)
    else $error("dac update in frame");
  chk_ref_follow: assert property ($stable(regs_o.ctrl_reg) [*2] |->
    ref_enable_o == !regs_o.ctrl_reg[`DACSP_REFDIS_BIT]) else $error("ref state");
  chk_pulse_clr: assert property (reset_pulse_o |=> !reset_pulse_o ##[0:2]
    (regs_o == 48'h0 && ref_enable_o)) else $error("full reset");
  chk_sdo_edge: assert property ($changed(sdo_o) && sdo_oe_o && $past(sdo_oe_o) |->
    $past(pins_i.sclk, 3) || $past(pins_i.sclk, 4) || $past(pins_i.sclk, 5) ||
    $past(pins_i.frame_n, 5)) else $error("sdo change off edge");
  chk_oe_rise: assert property ($rose(sdo_oe_o) |-> !pins_i.frame_n) else $error("oe rise");
  chk_rst_vals: assert property ($fell(sys_rst_i) |-> regs_o == 48'h0 && ref_enable_o &&
    !sdo_oe_o && !reset_pulse_o) else $error("reset values");
  cover property (reset_pulse_o);
  cover property ($rose(sdo_oe_o));
  cover property ($changed(regs_o.dac_reg));
endmodule
bind dacsp_port dacsp_port_assertions u_chk (.clk_sys_i, .sys_rst_i, .pins_i, .sdo_o,
  .sdo_oe_o, .regs_o, .ref_enable_o, .reset_pulse_o);
